// ===== core/adc_seq_map.vh
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
`define OFS_COMMAND 8'h00
`define OFS_MODE 8'h04
`define OFS_CH_ENABLE 8'h10
`define OFS_CH_DISABLE 8'h14
`define OFS_CH_STATUS 8'h18
`define OFS_STATUS 8'h1C
`define OFS_LAST_RESULT 8'h20
`define OFS_RESULT_BASE 8'h30
`define OFS_RESULT_LAST 8'h4C
`define CMD_SWRESET_BIT 0
`define CMD_START_BIT 1
`define MODE_HW_TRIG_BIT 0
`define MODE_TRIGSEL_LSB 1
`define MODE_LOW_RESOLUTION_SELECT_BIT 4
`define MODE_SLEEP_BIT 5
`define MODE_DIV_LSB 8
`define MODE_STARTUP_LSB 16
`define MODE_SHOLD_LSB 24
`define MODE_WRITE_MASK 32'h0F1F3F3F
`define MODE_RESET 32'h00000000
`define TRIGSEL_TIMER0 3'h0
`define TRIGSEL_TIMER1 3'h1
`define TRIGSEL_EXT 3'h6
`define STATUS_READY_BIT 16
`define STATUS_GOVR_BIT 17
`define CONV_CYCLES 4'hA
`define STARTUP_STEP 8'h08
`endif

// ===== core/adc_clock_divider.v
// Converter clock enable divider: one pulse every 2*(divider+1) master clocks.
`timescale 1ns/1ps
`default_nettype none
module adc_clock_divider (
  input wire clock, // Master clock.
  input wire reset, // Synchronous reset, active high.
  input wire run, // Divider runs while high.
  input wire [5:0] divide, // Divider field.
  output reg tick // One-cycle converter clock enable.
);
  reg [6:0] count_q;
  wire [6:0] limit;
  assign limit = {divide, 1'b1};
  // Counting to 2*(divide+1)-1 gives the period of one converter clock.
  always @(posedge clock)
  begin
    if (reset || !run)
    begin
      count_q <= 7'h00;
      tick <= 1'b0;
    end
    else if (count_q == limit)
    begin
      count_q <= 7'h00;
      tick <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule // adc_clock_divider
`default_nettype wire

// ===== core/sar_adc_sequencer_control.v
// Converter sequencer control with AHB-Lite registers, triggers, flags and DMA request.
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"
// Operation
// - Sample-hold cycles then ten converter clocks.
// - Converter clock from master clock divider.
// - Rate is master clock over 2*(field+1).
// - Reset gives 10-bit; select bit gives 8-bit.
// - Low resolution drops the two lower bits.
// - DMA size 16 bits, 8 in low resolution.
// - Result stored per channel and last result.
// - Set done and ready; ready rise requests DMA.
// - Channel result read clears its done flag.
// - Last result read clears ready and done.
// - Unread channel result overwritten sets channel overrun.
// - Result while ready high sets global overrun.
// - Status read clears all overrun flags.
// - Command start bit issues software trigger.
// - Enabled hardware trigger starts on rising edge.
// - Codes 000, 001 timers; 110 external pin.
// - One start converts all enabled channels.
// - DMA only for enabled channels; set/clear enables.
// - Software trigger works alongside hardware trigger.
// - Sleep: wake, start-up wait, convert, sleep.
// - Triggers during a sequence are ignored.
// - Normal mode keeps converter clocked after first.
// - Start-up is 8*(field+1) converter clocks.
// - Sample-hold is field+1 converter clocks.
module sar_adc_sequencer_control (
  input wire clock, // Master clock, 200 MHz.
  input wire reset, // Synchronous reset, active high.
  input wire hsel, // AHB slave select.
  input wire [31:0] haddr, // AHB address.
  input wire [1:0] htrans, // AHB transfer type.
  input wire hwrite, // AHB write.
  input wire [2:0] hsize, // AHB size.
  input wire [31:0] hwdata, // AHB write data.
  input wire hready, // AHB bus ready.
  output reg [31:0] hrdata, // AHB read data.
  output reg hreadyout, // AHB slave ready.
  output reg hresp, // AHB response, always OKAY.
  input wire timer0_waveform, // Timer channel 0 waveform output.
  input wire timer1_waveform, // Timer channel 1 waveform output.
  input wire external_trigger_pin, // External trigger pin, asynchronous.
  input wire [9:0] sar_result, // Converter cell result after the last bit.
  output reg converter_enable, // Converter cell powered up.
  output reg converter_clock_en, // Converter clock gate enable.
  output reg [2:0] mux_select, // Analog multiplexer channel.
  output reg sample_hold, // Sample-and-hold phase active.
  output reg convert_active, // Bit conversion phase active.
  output reg dma_request, // One-cycle DMA transfer request.
  output reg dma_size_16 // DMA transfer width: 1 is 16-bit, 0 is 8-bit.
);
  localparam ST_IDLE = 2'h0;
  localparam ST_STARTUP = 2'h1;
  localparam ST_SAMPLE = 2'h2;
  localparam ST_CONVERT = 2'h3;

  reg [31:0] mode_q;
  reg [7:0] chan_en_q;
  reg [7:0] done_q;
  reg [7:0] ovr_q;
  reg ready_q;
  reg govr_q;
  reg [9:0] data_q [0:7];
  reg [9:0] last_q;
  reg [2:0] last_ch_q;
  reg [1:0] state_q;
  reg [2:0] chan_q;
  reg [8:0] count_q;
  reg clocked_q;
  reg ap_valid_q;
  reg ap_write_q;
  reg [7:0] ap_addr_q;
  reg sw_start_q;
  reg sw_reset_q;
  reg ext_meta_q;
  reg ext_sync_q;
  reg trig_prev_q;
  reg [7:0] done_d;
  reg [7:0] ovr_d;
  reg ready_d;
  reg govr_d;
  reg trig_sel;
  reg [3:0] next_ch;
  reg [31:0] rdata_d;
  wire tick;
  wire ap_take;
  wire wr;
  wire rd;
  wire srst;
  wire hw_rise;
  wire start;
  wire finish;
  wire [9:0] result;
  wire low_resolution_select;
  wire [3:0] first_ch;
  wire [3:0] addr_idx;
  wire [3:0] ap_idx;
  integer i;

  // Channel index of a result register address, used by read and clear logic.
  function [3:0] result_index;
    input [7:0] addr;
    begin
      if (addr >= `OFS_RESULT_BASE && addr <= `OFS_RESULT_LAST)
        result_index = {1'b1, addr[4:2] - 3'h4};
      else
        result_index = 4'h0;
    end
  endfunction

  // First enabled channel at or above a position; bit 3 set means none.
  function [3:0] first_enabled;
    input [7:0] en;
    input [3:0] from;
    integer k;
    begin
      first_enabled = 4'h8;
      for (k = 7; k >= 0; k = k - 1)
        if (en[k] && k >= from)
          first_enabled = k[3:0];
    end
  endfunction

  assign low_resolution_select = mode_q[`MODE_LOW_RESOLUTION_SELECT_BIT];
  assign srst = reset | sw_reset_q;
  assign ap_take = hsel & hready & htrans[1];
  assign wr = ap_valid_q & ap_write_q;
  assign rd = ap_valid_q & ~ap_write_q;
  assign first_ch = first_enabled(chan_en_q, 4'h0);
  assign addr_idx = result_index(haddr[7:0]);
  assign ap_idx = result_index(ap_addr_q);

  // The converter clock enable runs only while the cell is clocked.
  adc_clock_divider u_div (
    .clock(clock),
    .reset(srst),
    .run(converter_clock_en),
    .divide(mode_q[`MODE_DIV_LSB +: 6]),
    .tick(tick)
  );

  // Address phase capture; the slave answers with no wait states.
  always @(posedge clock)
  begin
    if (reset)
    begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      ap_valid_q <= ap_take;
      ap_write_q <= hwrite;
      ap_addr_q <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data is registered from the address phase so hrdata is a flip-flop.
  always @*
  begin
    rdata_d = 32'h00000000;
    if (haddr[7:0] == `OFS_MODE)
      rdata_d = mode_q;
    else if (haddr[7:0] == `OFS_CH_STATUS)
      rdata_d = {24'h000000, chan_en_q};
    else if (haddr[7:0] == `OFS_STATUS)
      rdata_d = {14'h0000, govr_q, ready_q, ovr_q, done_q};
    else if (haddr[7:0] == `OFS_LAST_RESULT)
      rdata_d = {22'h000000, last_q};
    else if (addr_idx[3])
      rdata_d = {22'h000000, data_q[addr_idx[2:0]]};
  end

  always @(posedge clock)
  begin
    if (reset)
      hrdata <= 32'h00000000;
    else if (ap_take && !hwrite)
      hrdata <= rdata_d;
  end

  // Write side: mode, channel set/clear and one-cycle command pulses.
  always @(posedge clock)
  begin
    sw_start_q <= 1'b0;
    sw_reset_q <= 1'b0;
    if (srst)
    begin
      mode_q <= `MODE_RESET;
      chan_en_q <= 8'h00;
    end
    else if (wr)
    begin
      if (ap_addr_q == `OFS_COMMAND)
      begin
        sw_start_q <= hwdata[`CMD_START_BIT];
        sw_reset_q <= hwdata[`CMD_SWRESET_BIT];
      end
      else if (ap_addr_q == `OFS_MODE)
        mode_q <= hwdata & `MODE_WRITE_MASK;
      else if (ap_addr_q == `OFS_CH_ENABLE)
        chan_en_q <= chan_en_q | hwdata[7:0];
      else if (ap_addr_q == `OFS_CH_DISABLE)
        chan_en_q <= chan_en_q & ~hwdata[7:0];
    end
  end

  // Two flops on the pin; the edge detector reads only the second.
  always @(posedge clock)
  begin
    if (reset)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end
    else
    begin
      ext_meta_q <= external_trigger_pin;
      ext_sync_q <= ext_meta_q;
    end
  end

  // Trigger selection; reserved codes never trigger. Timers are assumed in waveform mode.
  always @*
  begin
    if (mode_q[`MODE_TRIGSEL_LSB +: 3] == `TRIGSEL_TIMER0)
      trig_sel = timer0_waveform;
    else if (mode_q[`MODE_TRIGSEL_LSB +: 3] == `TRIGSEL_TIMER1)
      trig_sel = timer1_waveform;
    else if (mode_q[`MODE_TRIGSEL_LSB +: 3] == `TRIGSEL_EXT)
      trig_sel = ext_sync_q;
    else
      trig_sel = 1'b0;
  end

  always @(posedge clock)
  begin
    if (srst)
      trig_prev_q <= 1'b0;
    else
      trig_prev_q <= trig_sel;
  end

  assign hw_rise = mode_q[`MODE_HW_TRIG_BIT] & trig_sel & ~trig_prev_q;
  assign start = (state_q == ST_IDLE) & (sw_start_q | hw_rise);
  assign finish = (state_q == ST_CONVERT) & tick & (count_q == 9'h000);
  assign result = low_resolution_select ? {2'b00, sar_result[9:2]} : sar_result;

  // Next enabled channel after the one being converted.
  always @*
  begin
    next_ch = first_enabled(chan_en_q, {1'b0, chan_q} + 4'h1);
  end

  // Sequencer: optional start-up, then sample-hold and ten clocks per channel.
  always @(posedge clock)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      chan_q <= 3'h0;
      count_q <= 9'h000;
      clocked_q <= 1'b0;
      converter_enable <= 1'b0;
      converter_clock_en <= 1'b0;
      mux_select <= 3'h0;
      sample_hold <= 1'b0;
      convert_active <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          sample_hold <= 1'b0;
          convert_active <= 1'b0;
          converter_clock_en <= clocked_q & ~mode_q[`MODE_SLEEP_BIT];
          converter_enable <= clocked_q & ~mode_q[`MODE_SLEEP_BIT];
          if (start && !first_ch[3])
          begin
            chan_q <= first_ch[2:0];
            mux_select <= first_ch[2:0];
            converter_enable <= 1'b1;
            converter_clock_en <= 1'b1;
            if (mode_q[`MODE_SLEEP_BIT] || !clocked_q)
            begin
              state_q <= ST_STARTUP;
              count_q <= {1'b0, mode_q[`MODE_STARTUP_LSB +: 5], 3'h7};
            end
            else
            begin
              state_q <= ST_SAMPLE;
              sample_hold <= 1'b1;
              count_q <= {5'h00, mode_q[`MODE_SHOLD_LSB +: 4]};
            end
          end
        end
        ST_STARTUP:
          if (tick)
          begin
            if (count_q == 9'h000)
            begin
              state_q <= ST_SAMPLE;
              sample_hold <= 1'b1;
              count_q <= {5'h00, mode_q[`MODE_SHOLD_LSB +: 4]};
            end
            else
              count_q <= count_q - 9'h001;
          end
        ST_SAMPLE:
          if (tick)
          begin
            if (count_q == 9'h000)
            begin
              state_q <= ST_CONVERT;
              sample_hold <= 1'b0;
              convert_active <= 1'b1;
              count_q <= {5'h00, `CONV_CYCLES} - 9'h001;
            end
            else
              count_q <= count_q - 9'h001;
          end
        ST_CONVERT:
          if (tick)
          begin
            if (count_q == 9'h000)
            begin
              clocked_q <= 1'b1;
              convert_active <= 1'b0;
              if (next_ch[3])
              begin
                state_q <= ST_IDLE;
                converter_enable <= ~mode_q[`MODE_SLEEP_BIT];
                converter_clock_en <= ~mode_q[`MODE_SLEEP_BIT];
              end
              else
              begin
                state_q <= ST_SAMPLE;
                chan_q <= next_ch[2:0];
                mux_select <= next_ch[2:0];
                sample_hold <= 1'b1;
                count_q <= {5'h00, mode_q[`MODE_SHOLD_LSB +: 4]};
              end
            end
            else
              count_q <= count_q - 9'h001;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Flag next values: a completing conversion wins over a read that clears.
  always @*
  begin
    done_d = done_q;
    ovr_d = ovr_q;
    ready_d = ready_q;
    govr_d = govr_q;
    if (rd && ap_idx[3])
      done_d[ap_idx[2:0]] = 1'b0;
    if (rd && ap_addr_q == `OFS_LAST_RESULT)
    begin
      ready_d = 1'b0;
      done_d[last_ch_q] = 1'b0;
    end
    if (rd && ap_addr_q == `OFS_STATUS)
    begin
      ovr_d = 8'h00;
      govr_d = 1'b0;
    end
    if (finish)
    begin
      if (done_q[chan_q])
        ovr_d[chan_q] = 1'b1;
      if (ready_q)
        govr_d = 1'b1;
      done_d[chan_q] = 1'b1;
      ready_d = 1'b1;
    end
  end

  // Result storage, flags and DMA request.
  always @(posedge clock)
  begin
    if (srst)
    begin
      done_q <= 8'h00;
      ovr_q <= 8'h00;
      ready_q <= 1'b0;
      govr_q <= 1'b0;
      last_q <= 10'h000;
      last_ch_q <= 3'h0;
      dma_request <= 1'b0;
      dma_size_16 <= 1'b1;
      for (i = 0; i < 8; i = i + 1)
        data_q[i] <= 10'h000;
    end
    else
    begin
      done_q <= done_d;
      ovr_q <= ovr_d;
      ready_q <= ready_d;
      govr_q <= govr_d;
      dma_size_16 <= ~low_resolution_select;
      // A channel disabled mid-conversion still converts; the enable gate keeps its request off.
      dma_request <= ready_d & ~ready_q & chan_en_q[chan_q];
      if (finish)
      begin
        data_q[chan_q] <= result;
        last_q <= result;
        last_ch_q <= chan_q;
      end
    end
  end
endmodule // sar_adc_sequencer_control
`default_nettype wire

// ===== test/adc_seq_props.sv
// Concurrent checks on the converter control ports.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_props (
  input wire logic clock, // Master clock.
  input wire logic reset, // Sync reset.
  input wire logic hreadyout, // Slave ready.
  input wire logic hresp, // Bus response.
  input wire logic converter_enable, // Cell power.
  input wire logic converter_clock_en, // Clock gate.
  input wire logic [2:0] mux_select, // Channel.
  input wire logic sample_hold, // Sampling phase.
  input wire logic convert_active, // Bit phase.
  input wire logic dma_request, // DMA pulse.
  input wire logic dma_size_16 // DMA width.
);
  // All checks share the master clock and drop out during reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // The bus answer is always zero-wait and OKAY.
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  dma_pulse_a: assert property (dma_request |=> !dma_request)
    else $error("dma request longer than one cycle");
  phase_excl_a: assert property (!(sample_hold && convert_active))
    else $error("sampling and converting at once");
  sample_first_a: assert property ($rose(convert_active) |-> $past(sample_hold))
    else $error("conversion began without sampling");
  // Ten ticks of at least two clocks each can never end inside eight clocks.
  conv_len_a: assert property ($rose(convert_active) |-> convert_active [*8])
    else $error("conversion phase cut short");
  powered_a: assert property ((sample_hold || convert_active) |->
    converter_enable && converter_clock_en)
    else $error("converter used while unpowered");
  mux_hold_a: assert property (convert_active && $past(convert_active) |->
    $stable(mux_select))
    else $error("channel changed mid conversion");
  reset_val_a: assert property ($fell(reset) |->
    dma_size_16 && !converter_enable && !dma_request)
    else $error("wrong output after reset");
  // Main scenarios reached.
  cover property (dma_request);
  cover property ($fell(converter_enable));
  cover property ($rose(sample_hold));
endmodule // adc_seq_props
bind sar_adc_sequencer_control adc_seq_props chk_u (.clock, .reset, .hreadyout, .hresp,
  .converter_enable, .converter_clock_en, .mux_select, .sample_hold, .convert_active,
  .dma_request, .dma_size_16);
`default_nettype wire

// ===== test/sar_cell_model.sv
// Behavioural converter cell answering for the selected channel.
`timescale 1ns/1ps
`default_nettype none
module sar_cell_model (
  input wire logic convert_active, // Bit phase.
  input wire logic [2:0] mux_select, // Channel.
  output logic [9:0] sar_result // Cell output.
);
  // Outside conversion the value is inverted, so stale data never looks right.
  assign sar_result = convert_active ? {mux_select, 7'h2B} : ~{mux_select, 7'h2B};
endmodule // sar_cell_model
`default_nettype wire

// ===== test/sar_adc_sequencer_control_tb.sv
// Self-checking bench for the converter sequencer control.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"
module sar_adc_sequencer_control_tb;
  logic clock, reset, hsel, hwrite, hreadyout, hresp, converter_enable;
  logic converter_clock_en, sample_hold, convert_active, dma_request, dma_size_16;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [2:0] trig, mux_select;
  logic [9:0] sar_result;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  sar_adc_sequencer_control dut_u (.clock, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .timer0_waveform(trig[0]), .timer1_waveform(trig[1]),
    .external_trigger_pin(trig[2]), .sar_result, .converter_enable,
    .converter_clock_en, .mux_select, .sample_hold, .convert_active,
    .dma_request, .dma_size_16);
  sar_cell_model cell_u (.convert_active, .mux_select, .sar_result);
  // Clock of 5 ns.
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Cuts a hung run short; every scenario needs far fewer cycles.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude;
  begin
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // One single transfer; read data is taken at the edge ending the data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
  begin
    bus(1'b0, a, 32'h0);
    chk(r, e);
  end
  endtask
  task automatic start;
  begin
    bus(1'b1, `OFS_COMMAND, 32'h2);
  end
  endtask
  // Waits for n finished conversions; only a rising ready flag gives a DMA pulse.
  task automatic seq(input int n, input int d);
    int k, c;
    logic p;
  begin
    k = 0;
    c = 0;
    p = 1'b0;
    for (int t = 0; t < 3000 && c < n; t++)
    begin
      @(posedge clock);
      c += (p && convert_active === 1'b0);
      p = (convert_active === 1'b1);
      k += (dma_request === 1'b1);
    end
    chk(c, n);
    chk(k, d);
  end
  endtask
  // No sampling or converting may appear; DMA alone would miss a run while ready is high.
  task automatic quiet;
    int k;
  begin
    k = 0;
    repeat (300) @(posedge clock) k += (sample_hold === 1'b1 || convert_active === 1'b1);
    chk(k, 0);
  end
  endtask
  // Timers are modelled as waveform-mode outputs.
  task automatic pulse(input logic [2:0] m);
  begin
    @(posedge clock);
    trig <= m;
    repeat (4) @(posedge clock);
    trig <= 3'h0;
  end
  endtask
  task automatic t_basic;
  begin
    rd(`OFS_MODE, 32'h0);
    rd(8'h08, 32'h0);
    bus(1'b1, `OFS_CH_ENABLE, 32'h85);
    bus(1'b1, `OFS_CH_DISABLE, 32'h80);
    rd(`OFS_CH_STATUS, 32'h5);
    start();
    seq(2, 1);
    rd(`OFS_STATUS, 32'h30005);
    rd(`OFS_LAST_RESULT, 32'h12B);
    rd(`OFS_STATUS, 32'h1);
    rd(`OFS_RESULT_BASE + 8'h08, 32'h12B);
    rd(`OFS_RESULT_BASE, 32'h2B);
    rd(`OFS_STATUS, 32'h0);
    chk(converter_clock_en, 1'b1);
    $display("test basic done");
  end
  endtask
  task automatic t_overrun;
  begin
    start();
    seq(2, 1);
    start();
    seq(2, 0);
    rd(`OFS_STATUS, 32'h30505);
    rd(`OFS_STATUS, 32'h10005);
    rd(`OFS_LAST_RESULT, 32'h12B);
    rd(`OFS_RESULT_BASE, 32'h2B);
    rd(`OFS_STATUS, 32'h0);
    $display("test overrun done");
  end
  endtask
  task automatic t_low_resolution_select;
  begin
    bus(1'b1, `OFS_MODE, 32'h10);
    repeat (2) @(posedge clock);
    chk(dma_size_16, 1'b0);
    start();
    seq(2, 1);
    rd(`OFS_RESULT_BASE + 8'h08, 32'h4A);
    rd(`OFS_LAST_RESULT, 32'h4A);
    rd(`OFS_RESULT_BASE, 32'h0A);
    bus(1'b1, `OFS_MODE, 32'h0);
    repeat (2) @(posedge clock);
    chk(dma_size_16, 1'b1);
    $display("test low_resolution_select done");
  end
  endtask
  // Every source in turn, a retrigger mid-sequence, then refused settings.
  task automatic t_trig;
    logic [2:0] code;
  begin
    for (int i = 0; i < 3; i++)
    begin
      code = (i == 2) ? 3'h6 : i[2:0];
      bus(1'b1, `OFS_MODE, {28'h0, code, 1'b1});
      pulse(3'h1 << i);
      repeat (10) @(posedge clock);
      pulse(3'h1 << i);
      seq(2, 1);
      quiet;
      start();
      seq(2, 0);
      rd(`OFS_LAST_RESULT, 32'h12B);
    end
    bus(1'b1, `OFS_MODE, 32'h5);
    pulse(3'h7);
    quiet;
    bus(1'b1, `OFS_MODE, 32'hC);
    pulse(3'h4);
    quiet;
    $display("test trig done");
  end
  endtask
  // Divider 1 gives a four-clock tick: start-up 64, sample 16, convert 40.
  task automatic t_sleep;
    int a, b, c;
  begin
    a = 0;
    b = 0;
    c = 0;
    bus(1'b1, `OFS_MODE, 32'h03010120);
    start();
    while (sample_hold !== 1'b1 && a < 500)
    begin
      @(posedge clock);
      a++;
    end
    while (sample_hold === 1'b1 && b < 500)
    begin
      @(posedge clock);
      b++;
    end
    while (convert_active === 1'b1 && c < 500)
    begin
      @(posedge clock);
      c++;
    end
    chk(a >= 64 && a <= 72, 1);
    chk(b, 16);
    chk(c, 40);
    a = 0;
    while (converter_enable === 1'b1 && a < 2000)
    begin
      @(posedge clock);
      a++;
    end
    chk(converter_clock_en, 1'b0);
    bus(1'b1, `OFS_COMMAND, 32'h1);
    rd(`OFS_MODE, 32'h0);
    rd(`OFS_CH_STATUS, 32'h0);
    rd(`OFS_STATUS, 32'h0);
    $display("test sleep done");
  end
  endtask
  // Reset for sixteen cycles, then the scenarios in turn.
  initial
  begin
    reset = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    trig = 3'h0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    t_basic();
    t_overrun();
    t_low_resolution_select();
    t_trig();
    t_sleep();
    conclude();
  end
endmodule // sar_adc_sequencer_control_tb
`default_nettype wire
